/* File: shared/oasc_defs.svh */
// offsets, field positions, encodings and reset values of the shutdown block
// assumes a 32-bit AHB-Lite register bus, one aligned word per register
`ifndef OASC_DEFS_SVH
`define OASC_DEFS_SVH

`define OASC_ADDR_CTRL    32'h0000_0000
`define OASC_ADDR_SRC     32'h0000_0004
`define OASC_ADDR_POL     32'h0000_0008
`define OASC_ADDR_STAT    32'h0000_000c
`define OASC_ADDR_IRQ_STS 32'h0000_0010
`define OASC_ADDR_IRQ_MSK 32'h0000_0014

`define OASC_CTL_ASE      0
`define OASC_CTL_ARSEN    1
`define OASC_CTL_AC_LSB   2
`define OASC_CTL_BD_LSB   4

`define OASC_SRC_PIN      0
`define OASC_SRC_CMP1     1
`define OASC_SRC_CMP2     2
`define OASC_SRC_CELL2    3

`define OASC_OVR_LOW      2'h0
`define OASC_OVR_HIGH     2'h1
`define OASC_OVR_TRI      2'h2
`define OASC_OVR_INACT    2'h3

`define OASC_IRQ_SHUT     0
`define OASC_IRQ_RESUME   1

`define OASC_RST_OVR      2'h0
`define OASC_RST_NIB      4'h0
`define OASC_RST_IRQ      2'h0
`define OASC_RST_FLT      4'hf

`endif

/* File: shared/oasc_pkg.sv */
// types of the shutdown block
// assumes the override codes of oasc_defs.svh; the state codes are one-hot literals here
package oasc_pkg;

  typedef enum logic [2:0]
  {
    OASC_ST_RUN  = 3'b001,
    OASC_ST_SHUT = 3'b010,
    OASC_ST_WAIT = 3'b100
  } oasc_state_t;

  typedef logic [1:0] oasc_ovr_t;

endpackage

/* File: verilog/oasc_sync.sv */
// two-flop level synchroniser for the fault inputs
// assumes inputs that are asynchronous to hclk
`timescale 1ns/10ps
module oasc_sync
#(
  parameter int                WIDTH   = 4,
  parameter logic [WIDTH-1:0]  RST_VAL = '1
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_nxt;

  always_comb
  begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_r <= RST_VAL;
      dout   <= RST_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end

endmodule

/* File: verilog/oasc_top.sv */
// output auto-shutdown control with AHB-Lite registers
// assumes waveform levels and rising events from a waveform core on hclk,
// and asynchronous, active-low fault sources
//
// What this block does
// - entering shutdown puts the override levels on the drive outputs at the next edge.
// - overrides stay until the first rising event after the shutdown bit clears.
// - writing a one to the shutdown event bit enters shutdown.
// - an active enabled fault overrides the drive latches with no software action.
// - any mix of sources may be enabled and each requests shutdown while low.
// - the sources are the remapped pin, comparator 1, comparator 2 and logic cell 2.
// - one override field serves outputs a and c, the other b and d.
// - each field picks low, high, high impedance or the inactive waveform level.
// - polarity applies to the inactive choice only, not to forced low or high.
// - the auto-restart bit picks software or automatic resumption.
// - without auto-restart software clears the bit, held set while a fault lasts.
// - with auto-restart hardware clears the bit once all enabled faults are gone.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "oasc_defs.svh"
module oasc_top
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  output logic             irq,
  input  wire logic        wave_a,
  input  wire logic        wave_b,
  input  wire logic        wave_c,
  input  wire logic        wave_d,
  input  wire logic        rise_event,
  input  wire logic        fault_pin,
  input  wire logic        comparator1_output,
  input  wire logic        comparator2_output,
  input  wire logic        logic_cell2_output,
  output logic             drive_out_a,
  output logic             drive_out_b,
  output logic             drive_out_c,
  output logic             drive_out_d,
  output logic             drive_oe_a,
  output logic             drive_oe_b,
  output logic             drive_oe_c,
  output logic             drive_oe_d,
  output logic             shutdown_active
);

  // **********************************************************
  // override level decode, returns {oe, level}
  // **********************************************************
  function automatic logic [1:0] ovr_drive(input oasc_pkg::oasc_ovr_t sel, input logic pol);
    case (sel)
      `OASC_OVR_LOW:   ovr_drive = 2'b10;
      `OASC_OVR_HIGH:  ovr_drive = 2'b11;
      `OASC_OVR_TRI:   ovr_drive = 2'b00;
      default:         ovr_drive = {1'b1, pol};
    endcase
  endfunction

  logic [3:0]            flt_s;
  logic                  wr_r,   wr_nxt;
  logic [31:0]           addr_r, addr_nxt;
  logic [31:0]           rdata_nxt;
  logic                  wr_ctrl, wr_src, wr_pol, wr_sts, wr_msk;
  logic                  ase_r,   ase_nxt;
  logic                  arsen_r, arsen_nxt;
  oasc_pkg::oasc_ovr_t   ac_r,    ac_nxt;
  oasc_pkg::oasc_ovr_t   bd_r,    bd_nxt;
  logic [3:0]            src_r,   src_nxt;
  logic [3:0]            pol_r,   pol_nxt;
  logic [1:0]            sts_r,   sts_nxt;
  logic [1:0]            msk_r,   msk_nxt;
  logic                  irq_nxt;
  logic                  fault_req;
  oasc_pkg::oasc_state_t st_r,    st_nxt;
  logic [1:0]            da, db, dc, dd;
  logic                  ovr_on;

  // **********************************************************
  // fault synchronisers
  // **********************************************************
  oasc_sync #(.WIDTH(4), .RST_VAL(`OASC_RST_FLT)) u_sync
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({logic_cell2_output, comparator2_output, comparator1_output, fault_pin}),
    .dout    (flt_s)
  );

  // **********************************************************
  // bus slave, zero wait states
  // **********************************************************
  always_comb
  begin
    wr_nxt   = hsel & htrans[1] & hready & hwrite;
    addr_nxt = (hsel & htrans[1] & hready) ? haddr : addr_r;
    wr_ctrl  = wr_r & (addr_r == `OASC_ADDR_CTRL);
    wr_src   = wr_r & (addr_r == `OASC_ADDR_SRC);
    wr_pol   = wr_r & (addr_r == `OASC_ADDR_POL);
    wr_sts   = wr_r & (addr_r == `OASC_ADDR_IRQ_STS);
    wr_msk   = wr_r & (addr_r == `OASC_ADDR_IRQ_MSK);
    rdata_nxt = 32'h0000_0000;
    if (hsel & htrans[1] & hready & ~hwrite)
    begin
      case (haddr)
        `OASC_ADDR_CTRL:    rdata_nxt = {26'h0, bd_nxt, ac_nxt, arsen_nxt, ase_nxt};
        `OASC_ADDR_SRC:     rdata_nxt = {28'h0, src_nxt};
        `OASC_ADDR_POL:     rdata_nxt = {28'h0, pol_nxt};
        `OASC_ADDR_STAT:    rdata_nxt = {23'h0, fault_req, flt_s, 1'b0, st_nxt};
        `OASC_ADDR_IRQ_STS: rdata_nxt = {30'h0, sts_nxt};
        `OASC_ADDR_IRQ_MSK: rdata_nxt = {30'h0, msk_nxt};
        default:            rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_r      <= 1'b0;
      addr_r    <= 32'h0000_0000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_r      <= wr_nxt;
      addr_r    <= addr_nxt;
      hrdata    <= rdata_nxt;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // **********************************************************
  // control registers and shutdown event bit
  // **********************************************************
  always_comb
  begin
    fault_req = |(src_r & ~flt_s);
    arsen_nxt = wr_ctrl ? hwdata[`OASC_CTL_ARSEN] : arsen_r;
    ac_nxt    = wr_ctrl ? hwdata[`OASC_CTL_AC_LSB +: 2] : ac_r;
    bd_nxt    = wr_ctrl ? hwdata[`OASC_CTL_BD_LSB +: 2] : bd_r;
    src_nxt   = wr_src ? hwdata[3:0] : src_r;
    pol_nxt   = wr_pol ? hwdata[3:0] : pol_r;
    ase_nxt   = wr_ctrl ? hwdata[`OASC_CTL_ASE] : ase_r;
    if (arsen_r & ase_r & ~fault_req & ~(wr_ctrl & hwdata[`OASC_CTL_ASE]))
      ase_nxt = 1'b0;
    if (fault_req)
      ase_nxt = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ase_r   <= 1'b0;
      arsen_r <= 1'b0;
      ac_r    <= `OASC_RST_OVR;
      bd_r    <= `OASC_RST_OVR;
      src_r   <= `OASC_RST_NIB;
      pol_r   <= `OASC_RST_NIB;
    end
    else
    begin
      ase_r   <= ase_nxt;
      arsen_r <= arsen_nxt;
      ac_r    <= ac_nxt;
      bd_r    <= bd_nxt;
      src_r   <= src_nxt;
      pol_r   <= pol_nxt;
    end
  end

  // **********************************************************
  // shutdown state: run, shut, wait for rising event
  // **********************************************************
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      oasc_pkg::OASC_ST_RUN:
        if (ase_nxt)
          st_nxt = oasc_pkg::OASC_ST_SHUT;
      oasc_pkg::OASC_ST_SHUT:
        if (!ase_nxt)
          st_nxt = oasc_pkg::OASC_ST_WAIT;
      oasc_pkg::OASC_ST_WAIT:
        if (ase_nxt)
          st_nxt = oasc_pkg::OASC_ST_SHUT;
        else if (rise_event)
          st_nxt = oasc_pkg::OASC_ST_RUN;
      default:
        st_nxt = oasc_pkg::OASC_ST_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= oasc_pkg::OASC_ST_RUN;
    else
      st_r <= st_nxt;
  end

  // **********************************************************
  // interrupt status, write one to clear, set wins
  // **********************************************************
  always_comb
  begin
    sts_nxt = sts_r & ~(wr_sts ? hwdata[1:0] : 2'b00);
    if (st_r == oasc_pkg::OASC_ST_RUN && st_nxt == oasc_pkg::OASC_ST_SHUT)
      sts_nxt[`OASC_IRQ_SHUT] = 1'b1;
    if (st_r == oasc_pkg::OASC_ST_WAIT && st_nxt == oasc_pkg::OASC_ST_RUN)
      sts_nxt[`OASC_IRQ_RESUME] = 1'b1;
    msk_nxt = wr_msk ? hwdata[1:0] : msk_r;
    irq_nxt = |(sts_nxt & msk_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sts_r <= `OASC_RST_IRQ;
      msk_r <= `OASC_RST_IRQ;
      irq   <= 1'b0;
    end
    else
    begin
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      irq   <= irq_nxt;
    end
  end

  // **********************************************************
  // drive outputs
  // **********************************************************
  always_comb
  begin
    ovr_on = (st_nxt != oasc_pkg::OASC_ST_RUN);
    da = ovr_on ? ovr_drive(ac_r, pol_r[0]) : {1'b1, wave_a ^ pol_r[0]};
    dc = ovr_on ? ovr_drive(ac_r, pol_r[2]) : {1'b1, wave_c ^ pol_r[2]};
    db = ovr_on ? ovr_drive(bd_r, pol_r[1]) : {1'b1, wave_b ^ pol_r[1]};
    dd = ovr_on ? ovr_drive(bd_r, pol_r[3]) : {1'b1, wave_d ^ pol_r[3]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {drive_oe_a, drive_out_a} <= 2'b10;
      {drive_oe_b, drive_out_b} <= 2'b10;
      {drive_oe_c, drive_out_c} <= 2'b10;
      {drive_oe_d, drive_out_d} <= 2'b10;
      shutdown_active           <= 1'b0;
    end
    else
    begin
      {drive_oe_a, drive_out_a} <= da;
      {drive_oe_b, drive_out_b} <= db;
      {drive_oe_c, drive_out_c} <= dc;
      {drive_oe_d, drive_out_d} <= dd;
      shutdown_active           <= ovr_on;
    end
  end

  // **********************************************************
  // checks
  // **********************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_waiting;
    st_r == oasc_pkg::OASC_ST_WAIT && !ase_nxt;
  endsequence

  sequence s_resumed;
    st_r == oasc_pkg::OASC_ST_RUN ##0 !shutdown_active;
  endsequence

  a_sw_set_enters: assert property (wr_ctrl && hwdata[0] |=> ase_r && shutdown_active)
    else $error("software set did not enter shutdown");
  a_fault_sets_bit: assert property (fault_req |=> ase_r ##0 shutdown_active)
    else $error("fault did not set shutdown bit");
  a_fault_holds: assert property (ase_r && fault_req && !arsen_r |=> ase_r)
    else $error("shutdown bit cleared during fault");
  a_auto_clear: assert property
    (arsen_r && ase_r && !fault_req && !wr_ctrl |=> !ase_r)
    else $error("auto restart did not clear shutdown bit");
  a_hold_to_rise: assert property (s_waiting and !rise_event |=> shutdown_active)
    else $error("override dropped before rising event");
  a_resume_rise: assert property (s_waiting ##0 rise_event |=> s_resumed)
    else $error("no resume on rising event");
  a_forced_low: assert property (ase_r && ac_r == `OASC_OVR_LOW |=> drive_oe_a && !drive_out_a)
    else $error("forced low wrong");
  a_forced_high: assert property
    (ase_r && bd_r == `OASC_OVR_HIGH |=> drive_oe_d && drive_out_d)
    else $error("forced high wrong");
  a_inactive_pol: assert property
    (ase_r && ac_r == `OASC_OVR_INACT |=> drive_out_c == $past(pol_r[2]))
    else $error("inactive level ignores polarity");
  a_tri_state: assert property (ase_r && bd_r == `OASC_OVR_TRI |=> !drive_oe_b)
    else $error("tri-state override drives pin");

endmodule

/* File: test/oasc_stage_model.sv */
// far-side model: fault sources and the power stage pins
// assumes bit order pin, comparator 1, comparator 2, logic cell 2 and a, b, c, d
`timescale 1ns/10ps
module oasc_stage_model
(
  input  wire logic [3:0] fault_cmd,
  input  wire logic [3:0] dout,
  input  wire logic [3:0] doe,
  output logic      [3:0] flt,
  output logic      [3:0] pins
);
  // ************************************************
  // fault lines and pin levels
  // ************************************************
  // a raised command pulls its fault line low
  assign flt = ~fault_cmd;
  // a released pin floats
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    assign pins[i] = doe[i] ? dout[i] : 1'bz;
  end
endmodule

/* File: test/oasc_top_tb.sv */
// self-checking bench of the auto-shutdown block
// assumes oasc_top, oasc_stage_model and oasc_defs.svh on the include path
`timescale 1ns/10ps
`include "oasc_defs.svh"
module oasc_top_tb;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        irq;
  logic        iq;
  logic        sd_act;
  logic [3:0]  wave;
  logic        rise_event;
  logic [3:0]  fault_cmd;
  logic [3:0]  flt;
  logic [3:0]  dout;
  logic [3:0]  doe;
  logic [3:0]  pins;
  logic [31:0] q;
  int          fails;
  int          checks;

  oasc_top dut_u
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
    .wave_a(wave[0]), .wave_b(wave[1]), .wave_c(wave[2]), .wave_d(wave[3]),
    .rise_event(rise_event), .fault_pin(flt[0]), .comparator1_output(flt[1]),
    .comparator2_output(flt[2]), .logic_cell2_output(flt[3]),
    .drive_out_a(dout[0]), .drive_out_b(dout[1]), .drive_out_c(dout[2]),
    .drive_out_d(dout[3]), .drive_oe_a(doe[0]), .drive_oe_b(doe[1]),
    .drive_oe_c(doe[2]), .drive_oe_d(doe[3]), .shutdown_active(sd_act)
  );

  oasc_stage_model stage_u
  (
    .fault_cmd(fault_cmd), .dout(dout), .doe(doe), .flt(flt), .pins(pins)
  );

  // ************************************************
  // clock, bus and check tasks
  // ************************************************
  initial
  begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one bus phase; answer taken at the edge that sees hready high
  task automatic phase();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1 && n < 20)
    begin
      n++;
      @(posedge hclk);
    end
    if (n >= 20)
    begin
      fails++;
      summarize();
    end
    q = hrdata;
    iq = irq;
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    phase();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    phase();
  endtask

  function automatic logic [31:0] ctl(input logic e, input logic r, input logic [1:0] ac,
                                      input logic [1:0] bd);
    return {26'h0, bd, ac, r, e};
  endfunction

  task automatic wctl(input logic e, input logic r, input logic [1:0] ac, input logic [1:0] bd);
    // fields land before the bit, so the first override already uses them
    if (e)
      bus(1'h1, `OASC_ADDR_CTRL, ctl(1'h0, r, ac, bd));
    bus(1'h1, `OASC_ADDR_CTRL, ctl(e, r, ac, bd));
  endtask

  task automatic chk_pins(input logic [3:0] exp);
    #1;
    check({28'h0, pins}, {28'h0, exp});
    @(posedge hclk);
  endtask

  task automatic chk_sd(input logic exp);
    #1;
    check({31'h0, sd_act}, {31'h0, exp});
    @(posedge hclk);
  endtask

  task automatic rise();
    rise_event <= 1'h1;
    @(posedge hclk);
    rise_event <= 1'h0;
  endtask

  task automatic t_reset();
    chk_pins(wave);
    chk_sd(1'h0);
    check({31'h0, hresp}, 32'h0);
    bus(1'h0, `OASC_ADDR_CTRL, 32'h0);
    check(q, 32'h0);
    bus(1'h0, `OASC_ADDR_SRC, 32'h0);
    check(q, 32'h0);
    bus(1'h0, 32'h0000_0040, 32'h0);
    check(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_soft();
    bus(1'h1, `OASC_ADDR_POL, 32'hf);
    wctl(1'h1, 1'h0, 2'h1, 2'h0);
    chk_pins(4'h5);
    chk_sd(1'h1);
    rise();
    chk_pins(4'h5);
    wctl(1'h0, 1'h0, 2'h1, 2'h0);
    chk_pins(4'h5);
    rise();
    chk_pins(~wave);
    chk_sd(1'h0);
    bus(1'h1, `OASC_ADDR_POL, 32'h0);
    bus(1'h0, `OASC_ADDR_IRQ_STS, 32'h0);
    check(q, 32'h3);
    check({31'h0, iq}, 32'h0);
    bus(1'h1, `OASC_ADDR_IRQ_MSK, 32'h1);
    bus(1'h0, `OASC_ADDR_IRQ_STS, 32'h0);
    check({31'h0, iq}, 32'h1);
    bus(1'h1, `OASC_ADDR_IRQ_STS, 32'h3);
    bus(1'h0, `OASC_ADDR_IRQ_STS, 32'h0);
    check(q, 32'h0);
    check({31'h0, iq}, 32'h0);
    $display("test software shutdown done");
  endtask

  task automatic t_modes();
    logic [3:0] exp;
    bus(1'h1, `OASC_ADDR_POL, 32'h5);
    for (int m = 0; m < 4; m++)
    begin
      case (2'(m))
        `OASC_OVR_LOW:  exp = 4'h0;
        `OASC_OVR_HIGH: exp = 4'hf;
        `OASC_OVR_TRI:  exp = 4'hz;
        default:        exp = 4'h5;
      endcase
      wctl(1'h1, 1'h0, 2'(m), 2'(m));
      chk_pins(exp);
      wctl(1'h0, 1'h0, 2'h0, 2'h0);
      rise();
      chk_pins(wave ^ 4'h5);
    end
    bus(1'h1, `OASC_ADDR_POL, 32'h0);
    $display("test override modes done");
  endtask

  task automatic t_fault();
    for (int i = 0; i < 4; i++)
    begin
      bus(1'h1, `OASC_ADDR_SRC, 32'h1 << i);
      fault_cmd <= 4'h1 << ((i + 1) % 4);
      repeat (4) @(posedge hclk);
      chk_pins(wave);
      fault_cmd <= 4'h1 << i;
      repeat (3) @(posedge hclk);
      chk_pins(4'h0);
      wctl(1'h0, 1'h0, 2'h0, 2'h0);
      bus(1'h0, `OASC_ADDR_CTRL, 32'h0);
      check(q, 32'h1);
      fault_cmd <= 4'h0;
      repeat (3) @(posedge hclk);
      wctl(1'h0, 1'h0, 2'h0, 2'h0);
      rise();
      chk_pins(wave);
    end
    $display("test fault sources done");
  endtask

  task automatic t_auto();
    int n;
    bus(1'h1, `OASC_ADDR_IRQ_STS, 32'h3);
    bus(1'h1, `OASC_ADDR_SRC, 32'hf);
    wctl(1'h0, 1'h1, 2'h3, 2'h2);
    fault_cmd <= 4'h4;
    repeat (3) @(posedge hclk);
    chk_pins(4'bz0z0);
    bus(1'h0, `OASC_ADDR_IRQ_STS, 32'h0);
    check(q, 32'h1);
    check({31'h0, iq}, 32'h1);
    bus(1'h0, `OASC_ADDR_STAT, 32'h0);
    check(q, 32'h0000_01b2);
    rise();
    chk_pins(4'bz0z0);
    fault_cmd <= 4'h0;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'h0 && n < 10)
    begin
      bus(1'h0, `OASC_ADDR_CTRL, 32'h0);
      n++;
    end
    if (q[0] !== 1'h0)
    begin
      fails++;
      summarize();
    end
    check(q, ctl(1'h0, 1'h1, 2'h3, 2'h2));
    chk_pins(4'bz0z0);
    rise();
    chk_pins(wave);
    bus(1'h1, `OASC_ADDR_IRQ_STS, 32'h3);
    $display("test auto restart done");
  endtask

  task automatic t_disable();
    wctl(1'h0, 1'h0, 2'h1, 2'h1);
    fault_cmd <= 4'h8;
    repeat (3) @(posedge hclk);
    chk_pins(4'hf);
    bus(1'h1, `OASC_ADDR_SRC, 32'h0);
    wctl(1'h0, 1'h0, 2'h1, 2'h1);
    bus(1'h0, `OASC_ADDR_CTRL, 32'h0);
    check(q, ctl(1'h0, 1'h0, 2'h1, 2'h1));
    rise();
    chk_pins(wave);
    fault_cmd <= 4'h0;
    $display("test source disable done");
  endtask

  initial
  begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wave = 4'h6;
    rise_event = 1'h0;
    fault_cmd = 4'h0;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset();
    t_soft();
    t_modes();
    t_fault();
    t_auto();
    t_disable();
    summarize();
  end
endmodule
